// ---- src/fpcu_pkg.sv ----
// Operation
// (RULE_01) Decode seven-bit command: read, ids, checksum read, program, erase, checksum run, remap.
// (RULE_02) Any other command code sets the fail flag and does nothing.
// (RULE_03) Self-writes or config/secure updates with their enable clear set the fail flag.
// (RULE_04) Secured secure-program, locked erase with debugger, brown-out, bad address, bad command fail.
// (RULE_05) Fail flag at bit 6 of control and status; write 1 in either clears; the code clears it only while lock_open is set.
// (RULE_06) Control bits 5,4,3,2 enable loader, config, application, secure updates.
// (RULE_07) Control bit 1 selects next boot source; after cold reset inverse of config bit.
// (RULE_08) Control bit 0 enables the programming function; operations need it set.
// (RULE_09) Control, trigger and frequency field writes accepted only with lock open.
// (RULE_10) Software keeps address word aligned, and page aligned for remap.
// (RULE_11) Checksum start address must be 512-byte aligned.
// (RULE_12) Data register gives program word, read result, checksum size and result.
// (RULE_13) Checksum read returns zero while running or when range was bad.
// (RULE_14) Trigger bit 0 starts an operation and clears when it finishes.
// (RULE_15) Status bit 0 reads busy while an operation runs.
// (RULE_16) Data-region base register holds config word 1, valid when region enable clear.
// (RULE_17) Frequency field bits 6:4; value 1 selects slow timing, others fast.
// (RULE_18) Status bit 31 set by secured init or software write; cleared by secure erase.
// (RULE_19) Vector window accesses redirect to vector page field with nine zero bits; the code appends the nine low processor address bits instead.
// (RULE_20) Vector page field bits 20:19 choose flash or SRAM; bits 18:12 read zero.
// (RULE_21) Status bits 2:1 show boot config, loaded after cold resets.
// (RULE_22) A detected fail condition keeps the operation from starting.
// (RULE_23) Flash accesses by the processor stall while an operation runs.
// (RULE_24) Checksum uses the standard 32-bit CRC polynomial.
// (RULE_25) Reserved bits read zero and ignore writes.
// (RULE_26) Protected writes are gated by the register lock open input.
package fpcu_pkg;
    localparam logic [7:0] OFS_CTL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_TRG = 8'h10;
    localparam logic [7:0] OFS_DATA_REGION_BASE = 8'h14;
    localparam logic [7:0] OFS_FTC = 8'h18;
    localparam logic [7:0] OFS_STS = 8'h40;
    localparam int FAIL_BIT = 6;
    localparam int FOM_LSB = 4;
    localparam int SECURE_CODE_ACTIVE_BIT = 31;
    localparam logic [6:0] CMD_READ = 7'h00;
    localparam logic [6:0] CMD_UID = 7'h04;
    localparam logic [6:0] CMD_MID = 7'h0B;
    localparam logic [6:0] CMD_DID = 7'h0C;
    localparam logic [6:0] CMD_CKRD = 7'h0D;
    localparam logic [6:0] CMD_PROG = 7'h21;
    localparam logic [6:0] CMD_ERASE = 7'h22;
    localparam logic [6:0] CMD_CKRUN = 7'h2D;
    localparam logic [6:0] CMD_REMAP = 7'h2E;
    localparam logic [2:0] FOM_SLOW = 3'h1;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] PAGE_MASK = 32'h000001FF;
    localparam logic [31:0] VEC_TOP = 32'h000001FF;
    localparam logic [31:0] SECURE_BASE = 32'h00200000;
    localparam logic [31:0] CONFIG_BASE = 32'h00300000;
    localparam logic [31:0] SRAM_BASE = 32'h20000000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : fpcu_pkg

// ---- src/fpcu_top.sv ----
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module fpcu_top #(
    parameter logic [31:0] APP_SIZE = 32'h00008000,
    parameter logic [31:0] LDR_BASE = 32'h00100000,
    parameter logic [31:0] LDR_SIZE = 32'h00001200,
    parameter logic [31:0] SEC_SIZE = 32'h00000200,
    parameter logic [31:0] MAKER_ID = 32'h0000005A, // Arbitrary value
    parameter logic [31:0] DEVICE_ID = 32'h00000123, // Arbitrary value
    parameter logic [31:0] UID_SEED = 32'h13572468 // Arbitrary value
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic lock_open,
    input wire logic cold_reset,
    input wire logic [31:0] user_config_word0,
    input wire logic [31:0] user_config_word1,
    input wire logic secure_init_active,
    input wire logic debugger_link,
    input wire logic chip_locked,
    input wire logic brown_out,
    input wire logic running_app,
    input wire logic running_ldr,
    output logic [31:0] flash_addr,
    output logic [31:0] flash_wdata,
    output logic flash_rd,
    output logic flash_wr,
    output logic flash_erase,
    input wire logic flash_done,
    input wire logic [31:0] flash_rdata,
    input wire logic [31:0] cpu_addr,
    output logic [31:0] cpu_mapped_addr,
    output logic cpu_stall,
    output logic boot_select,
    output logic [2:0] freq_optimisation_mode,
    output logic slow_timing
);
    typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_CRC} fpcu_state_t;

    fpcu_state_t state_reg, state_next;
    logic [31:0] addr_reg, data_reg, crc_reg, crc_left_reg, crc_ptr_reg, crc_start_reg;
    logic [6:0] cmd_reg;
    logic [5:0] ctl_reg; // bit 0 enable, 1 boot select, 2..5 update enables
    logic fail_reg, go_reg, secure_code_active_reg, crc_busy_reg, crc_bad_reg, cold_seen_reg;
    logic [2:0] fom_reg;
    logic [1:0] cbs_reg;
    logic [20:0] vector_page_map_reg;
    logic [31:0] data_region_base_reg;
    logic aw_held_reg, w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;

    // Write channel: address and data caught independently, response after both
    assign s_awready = !aw_held_reg && !s_bvalid;
    assign s_wready = !w_held_reg && !s_bvalid;
    wire wr_fire = aw_held_reg && w_held_reg && !s_bvalid;
    assign s_arready = !s_rvalid;
    wire rd_fire = s_arvalid && s_arready;

    // Write decode; byte strobes are ignored since every field sits in whole words
    wire wr_ctl = wr_fire && awaddr_reg == fpcu_pkg::OFS_CTL;
    wire wr_addr = wr_fire && awaddr_reg == fpcu_pkg::OFS_ADDR;
    wire wr_data = wr_fire && awaddr_reg == fpcu_pkg::OFS_DATA;
    wire wr_cmd = wr_fire && awaddr_reg == fpcu_pkg::OFS_CMD;
    wire wr_trg = wr_fire && awaddr_reg == fpcu_pkg::OFS_TRG;
    wire wr_ftc = wr_fire && awaddr_reg == fpcu_pkg::OFS_FTC;
    wire wr_sts = wr_fire && awaddr_reg == fpcu_pkg::OFS_STS;
    wire wr_known = wr_ctl | wr_addr | wr_data | wr_cmd | wr_trg | wr_ftc | wr_sts
        | (awaddr_reg == fpcu_pkg::OFS_DATA_REGION_BASE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            s_bvalid <= 1'b0;
            s_bresp <= fpcu_pkg::RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_wdata;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_known ? fpcu_pkg::RESP_OKAY : fpcu_pkg::RESP_SLVERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    wire fail_clr = lock_open && wdata_reg[fpcu_pkg::FAIL_BIT] && (wr_ctl || wr_sts); // see (RULE_05)
    wire start = wr_trg && lock_open && wdata_reg[0] && !go_reg; // see (RULE_09) see (RULE_14)

    // Legality of the triggered operation
    wire cmd_prog = cmd_reg == fpcu_pkg::CMD_PROG;
    wire cmd_erase = cmd_reg == fpcu_pkg::CMD_ERASE;
    wire cmd_valid = cmd_reg == fpcu_pkg::CMD_READ || cmd_reg == fpcu_pkg::CMD_UID
        || cmd_reg == fpcu_pkg::CMD_MID || cmd_reg == fpcu_pkg::CMD_DID
        || cmd_reg == fpcu_pkg::CMD_CKRD || cmd_prog || cmd_erase
        || cmd_reg == fpcu_pkg::CMD_CKRUN || cmd_reg == fpcu_pkg::CMD_REMAP; // see (RULE_01)
    wire modify = cmd_prog || cmd_erase;
    wire in_app = addr_reg < APP_SIZE;
    wire in_ldr = addr_reg >= LDR_BASE && addr_reg < LDR_BASE + LDR_SIZE;
    wire in_sec = addr_reg >= fpcu_pkg::SECURE_BASE
        && addr_reg < fpcu_pkg::SECURE_BASE + SEC_SIZE;
    wire in_cfg = addr_reg[31:4] == fpcu_pkg::CONFIG_BASE[31:4];
    wire in_sram = addr_reg[31:28] == fpcu_pkg::SRAM_BASE[31:28];
    wire addr_ok = in_app || in_ldr || in_sec || in_cfg
        || (cmd_reg == fpcu_pkg::CMD_REMAP && in_sram)
        || cmd_reg == fpcu_pkg::CMD_UID || cmd_reg == fpcu_pkg::CMD_MID
        || cmd_reg == fpcu_pkg::CMD_DID || cmd_reg == fpcu_pkg::CMD_CKRD;
    wire fail_perm = modify && ((in_app && running_app && !ctl_reg[3])
        || (in_ldr && running_ldr && !ctl_reg[5])
        || (in_cfg && !ctl_reg[4]) || (in_sec && !ctl_reg[2])); // see (RULE_03) see (RULE_06)
    wire fail_misc = (cmd_prog && in_sec && secure_code_active_reg)
        || (cmd_erase && chip_locked && debugger_link)
        || (modify && brown_out) || !addr_ok || !cmd_valid || !ctl_reg[0]; // see (RULE_04) see (RULE_02) see (RULE_08)
    wire fail_now = fail_perm || fail_misc;
    wire launch = start && !fail_now; // see (RULE_22)
    wire fail_set = start && fail_now;

    // CRC over one read word, most significant bit first; see (RULE_24)
    function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ fpcu_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    wire crc_range_ok = ((addr_reg | data_reg) & fpcu_pkg::PAGE_MASK) == 32'h00000000
        && data_reg != 32'h00000000 && (in_app || in_ldr || in_sec); // see (RULE_11)
    wire crc_step = state_reg == ST_CRC && flash_done;
    wire crc_last = crc_left_reg == 32'h00000004;
    wire flash_op_done = state_reg == ST_FLASH && flash_done;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (launch && cmd_reg == fpcu_pkg::CMD_CKRUN && crc_range_ok) begin
                    state_next = ST_CRC;
                end else if (launch && (cmd_reg == fpcu_pkg::CMD_READ || modify)) begin
                    state_next = ST_FLASH;
                end
            end
            ST_FLASH: if (flash_done) state_next = ST_IDLE;
            ST_CRC: if (flash_done && crc_last) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // Single-cycle commands finish at once; flash and checksum wait for the array
    wire quick_done = launch && state_next == ST_IDLE;
    wire op_done = quick_done || flash_op_done || (crc_step && crc_last);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            go_reg <= 1'b0;
            fail_reg <= 1'b0;
            crc_ptr_reg <= 32'h00000000;
            crc_left_reg <= 32'h00000000;
            crc_reg <= 32'h00000000;
            crc_start_reg <= 32'h00000000;
            crc_busy_reg <= 1'b0;
            crc_bad_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (start) go_reg <= 1'b1; // see (RULE_14)
            else if (op_done || go_reg && state_reg == ST_IDLE) go_reg <= 1'b0;
            if (fail_set) fail_reg <= 1'b1; // see (RULE_05)
            else if (fail_clr) fail_reg <= 1'b0;
            if (launch && cmd_reg == fpcu_pkg::CMD_CKRUN) begin
                crc_ptr_reg <= addr_reg;
                crc_left_reg <= data_reg;
                crc_start_reg <= addr_reg;
                crc_reg <= fpcu_pkg::CRC_INIT;
                crc_busy_reg <= crc_range_ok;
                crc_bad_reg <= !crc_range_ok;
            end else if (crc_step) begin
                crc_reg <= crc_word(crc_reg, flash_rdata);
                crc_ptr_reg <= crc_ptr_reg + 32'h00000004;
                crc_left_reg <= crc_left_reg - 32'h00000004;
                if (crc_last) crc_busy_reg <= 1'b0;
            end
        end
    end

    // Result word for the data register; see (RULE_12)
    wire [31:0] uid_word = UID_SEED ^ {30'h00000000, addr_reg[3:2]};
    wire [31:0] ck_word = (crc_busy_reg || crc_bad_reg || addr_reg != crc_start_reg)
        ? 32'h00000000 : crc_reg; // see (RULE_13)
    wire [31:0] quick_word = cmd_reg == fpcu_pkg::CMD_UID ? uid_word
        : cmd_reg == fpcu_pkg::CMD_MID ? MAKER_ID
        : cmd_reg == fpcu_pkg::CMD_DID ? DEVICE_ID
        : cmd_reg == fpcu_pkg::CMD_CKRD ? ck_word : data_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_reg <= 32'h00000000;
            data_reg <= 32'h00000000;
            cmd_reg <= 7'h00;
            fom_reg <= 3'h0;
            vector_page_map_reg <= 21'h000000;
        end else begin
            if (wr_addr && !go_reg) addr_reg <= wdata_reg;
            if (wr_cmd && !go_reg) cmd_reg <= wdata_reg[6:0];
            if (wr_ftc && lock_open) fom_reg <= wdata_reg[6:4]; // see (RULE_17) see (RULE_26)
            if (wr_data && !go_reg) data_reg <= wdata_reg;
            else if (quick_done) data_reg <= quick_word;
            else if (flash_op_done && cmd_reg == fpcu_pkg::CMD_READ) data_reg <= flash_rdata;
            if (launch && cmd_reg == fpcu_pkg::CMD_REMAP) begin
                vector_page_map_reg <= {addr_reg[29:28], 7'h00, addr_reg[20:9]}; // see (RULE_20)
            end
        end
    end

    // Control bits and cold-reset captures
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg <= 6'h00;
            secure_code_active_reg <= 1'b0;
            cbs_reg <= 2'b00;
            data_region_base_reg <= 32'h00000000;
            cold_seen_reg <= 1'b0;
        end else begin
            cold_seen_reg <= 1'b1;
            if (!cold_seen_reg && cold_reset) begin
                cbs_reg <= user_config_word0[7:6]; // see (RULE_21)
                ctl_reg[1] <= !user_config_word0[7]; // see (RULE_07)
                data_region_base_reg <= user_config_word1; // see (RULE_16)
                secure_code_active_reg <= secure_init_active; // see (RULE_18)
            end else begin
                if (wr_ctl && lock_open) ctl_reg <= wdata_reg[5:0]; // see (RULE_09) see (RULE_06)
                if (wr_sts && wdata_reg[fpcu_pkg::SECURE_CODE_ACTIVE_BIT]) secure_code_active_reg <= 1'b1; // see (RULE_18)
                else if (flash_op_done && cmd_erase && in_sec) secure_code_active_reg <= 1'b0;
            end
        end
    end

    // Read path; reserved bits read zero; see (RULE_25)
    wire [31:0] ctl_word = {25'h0000000, fail_reg, ctl_reg};
    wire [31:0] sts_word = {secure_code_active_reg, 1'b0, vector_page_map_reg, 2'b00, fail_reg, 3'b000,
        cbs_reg, go_reg}; // see (RULE_15) see (RULE_19)
    wire [31:0] rd_word = s_araddr == fpcu_pkg::OFS_CTL ? ctl_word
        : s_araddr == fpcu_pkg::OFS_ADDR ? addr_reg
        : s_araddr == fpcu_pkg::OFS_DATA ? data_reg
        : s_araddr == fpcu_pkg::OFS_CMD ? {25'h0000000, cmd_reg}
        : s_araddr == fpcu_pkg::OFS_TRG ? {31'h00000000, go_reg}
        : s_araddr == fpcu_pkg::OFS_DATA_REGION_BASE ? data_region_base_reg
        : s_araddr == fpcu_pkg::OFS_FTC ? {25'h0000000, fom_reg, 4'h0}
        : s_araddr == fpcu_pkg::OFS_STS ? sts_word : 32'h00000000;
    wire rd_known = s_araddr == fpcu_pkg::OFS_CTL || s_araddr == fpcu_pkg::OFS_ADDR
        || s_araddr == fpcu_pkg::OFS_DATA || s_araddr == fpcu_pkg::OFS_CMD
        || s_araddr == fpcu_pkg::OFS_TRG || s_araddr == fpcu_pkg::OFS_DATA_REGION_BASE
        || s_araddr == fpcu_pkg::OFS_FTC || s_araddr == fpcu_pkg::OFS_STS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= fpcu_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_word;
            s_rresp <= rd_known ? fpcu_pkg::RESP_OKAY : fpcu_pkg::RESP_SLVERR;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // Flash array side; strobes held for the whole operation
    assign flash_addr = state_reg == ST_CRC ? crc_ptr_reg : addr_reg;
    assign flash_wdata = data_reg;
    assign flash_rd = (state_reg == ST_FLASH && cmd_reg == fpcu_pkg::CMD_READ)
        || state_reg == ST_CRC;
    assign flash_wr = state_reg == ST_FLASH && cmd_prog;
    assign flash_erase = state_reg == ST_FLASH && cmd_erase;
    assign cpu_stall = state_reg != ST_IDLE; // see (RULE_23)
    // Remap only for boot modes with in-app programming; secure flash never sits here
    assign cpu_mapped_addr = (cpu_addr <= fpcu_pkg::VEC_TOP && !cbs_reg[0])
        ? {2'b00, vector_page_map_reg, cpu_addr[8:0]} : cpu_addr; // see (RULE_19)
    assign boot_select = ctl_reg[1];
    assign freq_optimisation_mode = fom_reg;
    assign slow_timing = fom_reg == fpcu_pkg::FOM_SLOW; // see (RULE_17)

    a_fail_on_bad: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_02)
        start && !cmd_valid |=> fail_reg && !cpu_stall) else $error("bad command not failed");
    a_perm_fail: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_03)
        start && fail_perm |=> fail_reg) else $error("permission fail missing");
    a_no_launch: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_22)
        start && fail_now |=> state_reg == ST_IDLE) else $error("failed op started");
    a_fail_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_05)
        fail_reg && !fail_clr |=> fail_reg) else $error("fail flag dropped");
    a_lock_gate: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_09)
        wr_ctl && !lock_open && !fail_set |=> $stable(ctl_reg)) else $error("locked write took");
    a_busy_stall: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_15)
        state_reg != ST_IDLE |-> go_reg && cpu_stall) else $error("busy not shown");
    a_go_clears: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_14)
        flash_op_done |=> !go_reg) else $error("trigger not cleared");
    a_slow_mode: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_17)
        wr_ftc && lock_open && wdata_reg[6:4] == fpcu_pkg::FOM_SLOW |=> slow_timing)
        else $error("timing select wrong");
    a_ck_zero: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_13)
        quick_done && cmd_reg == fpcu_pkg::CMD_CKRD && crc_bad_reg |=> data_reg == 32'h00000000)
        else $error("checksum not zero");
    // Array writes must hold the processor off from the first busy cycle
    sequence s_wr_launch;
        launch && modify;
    endsequence
    a_wr_launch: assert property (@(posedge aclk) disable iff (!aresetn) // see (RULE_23)
        s_wr_launch |=> cpu_stall && (flash_wr || flash_erase)) else $error("write not begun");
endmodule : fpcu_top
`default_nettype wire

// ---- test/fpcu_flash_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module fpcu_flash_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] flash_addr,
    input wire logic [31:0] flash_wdata,
    input wire logic flash_rd,
    input wire logic flash_wr,
    input wire logic flash_erase,
    input wire logic [3:0] delay,
    output logic flash_done,
    output logic [31:0] flash_rdata
);
    logic [31:0] mem [0:255];
    logic [31:0] data_reg = 32'h0;
    logic [3:0] wait_reg;
    wire logic req = flash_rd || flash_wr || flash_erase;
    // Off the done pulse the bus shows the inverse, never a stale word
    assign flash_rdata = flash_done ? data_reg : ~data_reg;
    initial for (int i = 0; i < 256; i++) mem[i] = 32'hFFFFFFFF;
    always @(posedge aclk) begin
        if (!aresetn || !req || flash_done) begin
            flash_done <= 1'b0;
            wait_reg <= 4'h0;
        end else if (wait_reg == delay) begin
            flash_done <= 1'b1;
            data_reg <= mem[flash_addr[9:2]];
            if (flash_wr) mem[flash_addr[9:2]] <= flash_wdata;
            if (flash_erase) for (int i = 0; i < 128; i++) mem[{flash_addr[9], i[6:0]}] <= '1;
        end else wait_reg <= wait_reg + 4'h1;
    end
endmodule : fpcu_flash_model
`default_nettype wire

// ---- test/flash_program_command_unit_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module flash_program_command_unit_test;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} fpcu_exp_t;
    logic aclk = 1'b0;
    logic aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, lock_open, cold_reset;
    logic secure_init_active, debugger_link, chip_locked, brown_out, running_app, running_ldr;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, user_config_word0, user_config_word1, cpu_addr, word, pd;
    logic [3:0] dly;
    wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, flash_rd, flash_wr;
    wire logic flash_erase, flash_done, cpu_stall, boot_select, slow_timing;
    wire logic [1:0] s_bresp, s_rresp;
    wire logic [31:0] s_rdata, flash_addr, flash_wdata, flash_rdata, cpu_mapped_addr;
    wire logic [2:0] freq_optimisation_mode;
    fpcu_exp_t exp_q[$];
    fpcu_exp_t e;
    int bad_count = 0, checks = 0, cycles = 0, seed = 75513;
    // Fail cases: invalid codes, self-write, brown-out, locked debug, range, secure, disabled
    logic [6:0] f_cmd[8] = '{7'h01, 7'h7F, 7'h21, 7'h22, 7'h22, 7'h00, 7'h21, 7'h00};
    logic [31:0] f_adr[8] = '{0, 0, 32'h100, 32'h200, 32'h200, 32'h10000, 32'h200000, 0};
    logic [3:0] f_in[8] = '{0, 0, 4'h4, 4'h8, 4'h3, 0, 0, 0};
    logic [7:0] zr[5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    fpcu_top fpcu_top_i (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .lock_open,
        .cold_reset, .user_config_word0, .user_config_word1, .secure_init_active,
        .debugger_link, .chip_locked, .brown_out, .running_app, .running_ldr, .flash_addr,
        .flash_wdata, .flash_rd, .flash_wr, .flash_erase, .flash_done, .flash_rdata,
        .cpu_addr, .cpu_mapped_addr, .cpu_stall, .boot_select, .freq_optimisation_mode,
        .slow_timing);
    fpcu_flash_model fpcu_flash_model_i (.aclk, .aresetn, .flash_addr, .flash_wdata,
        .flash_rd, .flash_wr, .flash_erase, .delay(dly), .flash_done, .flash_rdata);
    initial forever #2 aclk = ~aclk;
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_data
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_data({30'h0, got}, {30'h0, exp});
    endtask : cmp_resp
    task automatic end_of_test;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (s_rvalid && s_rready && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp_data(s_rdata & e.m, e.d & e.m);
            cmp_resp(s_rresp, e.r);
        end
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        cmp_resp(s_bresp, r);
        s_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, m = '1, input logic [1:0] r = 0);
        exp_q.push_back('{d, m, r});
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        word = s_rdata;
        s_rready <= 1'b0;
    endtask : rd
    task automatic op(input logic [6:0] c, input logic [31:0] a, d, input logic w = 1'b1);
        wr(fpcu_pkg::OFS_ADDR, a);
        wr(fpcu_pkg::OFS_DATA, d);
        wr(fpcu_pkg::OFS_CMD, {25'h0, c});
        wr(fpcu_pkg::OFS_TRG, 32'h1);
        for (int i = 0; i < 40 && w; i++) begin
            rd(fpcu_pkg::OFS_TRG, 0, 0);
            if (word[0] === 1'b0) break;
        end
    endtask : op
    initial begin
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, lock_open} = '0;
        {secure_init_active, debugger_link, chip_locked, brown_out, running_app} = '0;
        {s_awaddr, s_araddr, s_wdata, running_ldr} = '0;
        user_config_word0 = 32'h80;
        user_config_word1 = $random(seed);
        cold_reset = 1'b1;
        cpu_addr = 32'h10;
        dly = 4'h2;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(fpcu_pkg::OFS_CTL, 32'h0);
        rd(fpcu_pkg::OFS_STS, 32'h4);
        rd(fpcu_pkg::OFS_DATA_REGION_BASE, user_config_word1);
        foreach (zr[i]) rd(zr[i], 32'h0);
        wr(fpcu_pkg::OFS_CTL, 32'h3F);
        wr(fpcu_pkg::OFS_FTC, 32'h10);
        rd(fpcu_pkg::OFS_CTL, 32'h0);
        rd(fpcu_pkg::OFS_FTC, 32'h0);
        $display("reset and lock test done");
        lock_open <= 1'b1;
        wr(fpcu_pkg::OFS_FTC, 32'hFFFFFFFF);
        rd(fpcu_pkg::OFS_FTC, 32'h70);
        cmp_data({31'h0, slow_timing}, 32'h0);
        wr(fpcu_pkg::OFS_FTC, 32'h10);
        cmp_data({31'h0, slow_timing}, 32'h1);
        wr(fpcu_pkg::OFS_CTL, 32'h3);
        cmp_data({31'h0, boot_select}, 32'h1);
        wr(fpcu_pkg::OFS_CTL, 32'h1);
        $display("timing test done");
        pd = $random(seed);
        dly <= 4'hF;
        op(fpcu_pkg::CMD_PROG, 32'h100, pd, 1'b0);
        rd(fpcu_pkg::OFS_STS, 32'h1, 32'h1);
        cmp_data({31'h0, cpu_stall}, 32'h1);
        rd(fpcu_pkg::OFS_TRG, 32'h1);
        while (cpu_stall) @(posedge aclk);
        dly <= 4'($random(seed));
        op(fpcu_pkg::CMD_READ, 32'h100, ~pd);
        rd(fpcu_pkg::OFS_DATA, pd);
        rd(fpcu_pkg::OFS_STS, 32'h0, 32'h41);
        $display("program test done");
        for (int k = 0; k < 8; k++) begin
            {brown_out, running_app, chip_locked, debugger_link} <= f_in[k];
            wr(fpcu_pkg::OFS_CTL, {31'h0, k != 7});
            op(f_cmd[k], f_adr[k], 32'h0);
            rd(fpcu_pkg::OFS_STS, 32'h40, 32'h40);
            wr(k[0] ? fpcu_pkg::OFS_STS : fpcu_pkg::OFS_CTL, 32'h41);
            rd(fpcu_pkg::OFS_CTL, {31'h0, k != 7}, 32'h41);
        end
        {brown_out, running_app, chip_locked, debugger_link} <= '0;
        op(fpcu_pkg::CMD_READ, 32'h100, ~pd);
        rd(fpcu_pkg::OFS_DATA, ~pd);
        wr(fpcu_pkg::OFS_CTL, 32'h41);
        $display("fail test done");
        op(fpcu_pkg::CMD_CKRUN, 32'h10000, 32'h200);
        op(fpcu_pkg::CMD_CKRD, 32'h10000, 32'h12345678);
        rd(fpcu_pkg::OFS_DATA, 32'h0);
        wr(fpcu_pkg::OFS_STS, 32'h40);
        op(fpcu_pkg::CMD_REMAP, 32'h400, 32'h0);
        rd(fpcu_pkg::OFS_STS, 32'h400, 32'h3FFFFE00);
        cmp_data(cpu_mapped_addr, 32'h410);
        cpu_addr <= 32'h1000;
        @(posedge aclk);
        cmp_data(cpu_mapped_addr, 32'h1000);
        $display("checksum and remap test done");
        wr(8'h24, 32'h1, fpcu_pkg::RESP_SLVERR);
        rd(8'h20, 32'h0, '1, fpcu_pkg::RESP_SLVERR);
        wr(fpcu_pkg::OFS_STS, 32'h80000000);
        rd(fpcu_pkg::OFS_STS, 32'h80000000, 32'h80000000);
        $display("map test done");
        repeat (4) @(posedge aclk);
        end_of_test();
    end
endmodule : flash_program_command_unit_test
`default_nettype wire
